// ### shared/filt_pkg.sv
// Shared types and constants for the reading filter and relative stage
package filt_pkg;
  localparam int RD_W = 72;
  localparam int SUM_W = RD_W + 8;
  localparam int WIN_W = RD_W + 9;
  localparam int CNT_W = 7;
  localparam int DEPTH = 100;
  localparam int MED_DEPTH = 11;
  localparam int WORD_W = 32;
  localparam int HI_W = RD_W - 2 * WORD_W;

  localparam logic [CNT_W-1:0] CNT_MIN = 7'h01;
  localparam logic [CNT_W-1:0] CNT_MAX = 7'h64;
  localparam logic [CNT_W-1:0] CNT_DEF = 7'h0a;
  localparam logic [CNT_W-1:0] NOISE_TOLERANCE_PCT_MAX = 7'h69;
  localparam logic [CNT_W-1:0] NOISE_TOLERANCE_PCT_DEF = 7'h00;
  localparam logic [CNT_W-1:0] PCT_FULL = 7'h64;
  localparam logic [2:0] RANK_MIN = 3'h1;
  localparam logic [2:0] RANK_MAX = 3'h5;
  localparam logic [2:0] RANK_DEF = 3'h1;
  localparam logic signed [RD_W-1:0] BASE_MAX = 72'sh3635c952d2ce25c000;
  localparam logic signed [RD_W-1:0] BASE_MIN = -BASE_MAX;

  // Word addresses of the register port
  localparam logic [3:0] A_CTRL = 4'h0;
  localparam logic [3:0] A_COUNT = 4'h1;
  localparam logic [3:0] A_NOISE_TOLERANCE_PCT = 4'h2;
  localparam logic [3:0] A_RANK = 4'h3;
  localparam logic [3:0] A_BASE_LO = 4'h4;
  localparam logic [3:0] A_BASE_MID = 4'h5;
  localparam logic [3:0] A_BASE_HI = 4'h6;
  localparam logic [3:0] A_CMD = 4'h7;
  localparam logic [3:0] A_LAT_LO = 4'h8;
  localparam logic [3:0] A_LAT_MID = 4'h9;
  localparam logic [3:0] A_LAT_HI = 4'ha;
  localparam logic [3:0] A_STATUS = 4'hb;

  // Control word bits
  localparam int B_AVG_EN = 0;
  localparam int B_MOVING = 1;
  localparam int B_ADV_EN = 2;
  localparam int B_MED_EN = 3;
  localparam int B_REL_EN = 4;
  localparam int B_REL_MATH = 5;
  // Command word bits
  localparam int C_CONFIRM = 0;
  localparam int C_CANCEL = 1;
  localparam int C_CAPTURE = 2;

  typedef struct packed {
    logic             valid;
    logic [RD_W-1:0]  data;
  } rd_t;

  typedef struct packed {
    logic             wr;
    logic             rd;
    logic [3:0]       addr;
    logic [WORD_W-1:0] wdata;
  } bus_t;

  typedef struct packed {
    logic [CNT_W-1:0] average_count;
    logic             stack_control_select;
    logic [CNT_W-1:0] noise_tolerance_pct;
    logic             adv_en;
    logic             avg_en;
    logic [2:0]       med_rank;
    logic             med_en;
    logic             rel_en;
    logic             rel_src_math;
  } cfg_t;

  localparam cfg_t CFG_RST = '{average_count: CNT_DEF, stack_control_select: 1'b0,
                               noise_tolerance_pct: NOISE_TOLERANCE_PCT_DEF, adv_en: 1'b0, avg_en: 1'b0,
                               med_rank: RANK_DEF, med_en: 1'b0, rel_en: 1'b0,
                               rel_src_math: 1'b0};
endpackage

// ### hw/median_stage.sv
// Moving median over the newest 2*rank+1 readings, bypass when disabled
`timescale 1ns/1ps
`default_nettype none
module median_stage
  import filt_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       en_in,
  input  wire logic [2:0] rank_in,
  input  wire logic       clr_in,
  input  wire rd_t        smp_in,
  output var  rd_t        res_out
);
  typedef struct packed {
    logic [MED_DEPTH-1:0][RD_W-1:0] win;
    logic [3:0]                     fill;
    rd_t                            res;
  } med_st_t;

  med_st_t st_r;
  med_st_t st_nxt;

  always_comb begin
    int n;
    int lo;
    n = 2 * int'(rank_in) + 1;
    lo = 0;
    st_nxt = st_r;
    st_nxt.res.valid = 1'b0;
    if (clr_in) begin
      st_nxt.fill = '0;
    end else if (smp_in.valid) begin
      st_nxt.win = {st_r.win[MED_DEPTH-2:0], smp_in.data};
      if (int'(st_r.fill) < MED_DEPTH) begin
        st_nxt.fill = st_r.fill + 4'h1;
      end
      if (!en_in) begin
        st_nxt.res = smp_in;
      end else if (int'(st_nxt.fill) >= n) begin
        // Rank by count of smaller entries; ties broken by age
        for (int i = 0; i < MED_DEPTH; i++) begin
          lo = 0;
          for (int j = 0; j < MED_DEPTH; j++) begin
            if (i < n && j < n && j != i &&
                ($signed(st_nxt.win[j]) < $signed(st_nxt.win[i]) ||
                 (st_nxt.win[j] == st_nxt.win[i] && j < i))) begin
              lo++;
            end
          end
          if (i < n && lo == int'(rank_in)) begin
            st_nxt.res.data = st_nxt.win[i];
          end
        end
        st_nxt.res.valid = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign res_out = st_r.res;
endmodule
`default_nettype wire

// ### hw/avg_divide.sv
// Registered signed divide of the stack sum by its entry count
`timescale 1ns/1ps
`default_nettype none
module avg_divide
  import filt_pkg::*;
(
  input  wire logic                    clk_in,
  input  wire logic                    rst_n_in,
  input  wire logic                    valid_in,
  input  wire logic signed [SUM_W-1:0] sum_in,
  input  wire logic [CNT_W-1:0]        cnt_in,
  output var  rd_t                     res_out
);
  typedef struct packed {
    rd_t res;
  } div_st_t;

  div_st_t st_r;
  div_st_t st_nxt;

  always_comb begin
    logic signed [SUM_W-1:0] d;
    logic signed [SUM_W-1:0] q;
    d = SUM_W'(cnt_in);
    q = '0;
    st_nxt = st_r;
    st_nxt.res.valid = valid_in;
    // Count is never zero; truncates toward zero
    if (valid_in && cnt_in != '0) begin
      q = sum_in / d;
      st_nxt.res.data = q[RD_W-1:0];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign res_out = st_r.res;
endmodule
`default_nettype wire

// ### hw/reading_filter_and_relative_offset.sv
// Reading filter chain: median, averaging stack, relative baseline
// Functional notes
// - Average count accepts 1 to 100, resets to 10.
// - Stack control selects moving or repeating; repeating after reset.
// - Noise tolerance percent of range, 0 to 105, resets to 0.
// - Separate noise-window enable, reset clear; tolerance used only when set.
// - Averaging enable, reset clear; when clear readings pass unaltered.
// - Median rank 1 to 5, default 1; median enable reset clear.
// - Zero check or range change clears the averaging stack.
// - Settings held during entry; confirm applies at once, cancel discards.
// - With relative on, output equals reading minus baseline.
// - Same baseline on every range; range change keeps relative enable.
// - Over-range still flagged even with a large baseline.
// - A math on/off toggle clears relative enable unless a capture lands in the same cycle.
// - Capture latches present reading as baseline, then enables relative.
// - Baseline kept while relative is off, reused on re-enable.
// - Written baseline limited to +-9.999999e20, default zero.
// - Relative applies to filtered reading or math result, default reading.
// - Relative enable reset clear; latest adjusted reading readable.
// - Median runs first and feeds the averaging stack.
// - Moving averages every conversion; repeating one per full count then flushes.
// - Conversion outside noise window restarts stack and passes directly.
`timescale 1ns/1ps
`default_nettype none
module reading_filter_and_relative_offset
  import filt_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  input  wire bus_t              bus_in,
  output var  logic [WORD_W-1:0] rdata_out,
  input  wire rd_t               reading_in,
  input  wire logic [RD_W-1:0]   range_fs_in,
  input  wire logic              zero_check_in,
  input  wire logic              range_change_in,
  input  wire logic              math_toggle_in,
  input  wire rd_t               math_in,
  output var  rd_t               filt_out,
  output var  rd_t               rel_out,
  output var  logic              overflow_out
);
  typedef struct packed {
    cfg_t                           cfg;
    cfg_t                           pend;
    logic [RD_W-1:0]                base;
    logic [RD_W-1:0]                base_pend;
    logic [DEPTH-1:0][RD_W-1:0]     stk;
    logic [CNT_W-1:0]               ptr;
    logic [CNT_W-1:0]               fill;
    logic signed [SUM_W-1:0]        sum;
    logic [RD_W-1:0]                last_avg;
    logic                           have_avg;
    logic [RD_W-1:0]                src_last;
    rd_t                            rel;
    logic                           ovf;
    logic [WORD_W-1:0]              rdata;
  } st_t;

  st_t                     st_r;
  st_t                     st_nxt;
  rd_t                     med_res;
  rd_t                     div_res;
  logic                    div_v;
  logic signed [SUM_W-1:0] div_sum;
  logic [CNT_W-1:0]        div_cnt;
  logic                    confirm;
  logic                    capture;
  logic                    chg;
  logic                    clr;
  logic                    outside;
  rd_t                     src;

  ////////////////////////////////////////////////////////////////
  function automatic logic [RD_W:0] abs_w(input logic signed [RD_W:0] v);
    abs_w = v[RD_W] ? -v : v;
  endfunction
  function automatic logic [CNT_W-1:0] nxt_ptr(input logic [CNT_W-1:0] p,
                                              input logic [CNT_W-1:0] n);
    nxt_ptr = (p + CNT_MIN >= n) ? '0 : p + CNT_MIN;
  endfunction
  function automatic cfg_t clamp_cfg(input cfg_t c);
    clamp_cfg = c;
    if (c.average_count < CNT_MIN) clamp_cfg.average_count = CNT_MIN;
    if (c.average_count > CNT_MAX) clamp_cfg.average_count = CNT_MAX;
    if (c.noise_tolerance_pct > NOISE_TOLERANCE_PCT_MAX) clamp_cfg.noise_tolerance_pct = NOISE_TOLERANCE_PCT_MAX;
    if (c.med_rank < RANK_MIN) clamp_cfg.med_rank = RANK_MIN;
    if (c.med_rank > RANK_MAX) clamp_cfg.med_rank = RANK_MAX;
  endfunction
  function automatic logic [RD_W-1:0] clamp_base(input logic signed [RD_W-1:0] b);
    clamp_base = b;
    if (b > BASE_MAX) clamp_base = BASE_MAX;
    if (b < BASE_MIN) clamp_base = BASE_MIN;
  endfunction
  // Fields whose change invalidates the stacks
  function automatic logic [20:0] filt_key(input cfg_t c);
    filt_key = {c.average_count, c.stack_control_select, c.adv_en, c.avg_en,
                c.med_rank, c.med_en, c.noise_tolerance_pct};
  endfunction

  ////////////////////////////////////////////////////////////////
  assign confirm = bus_in.wr && bus_in.addr == A_CMD && bus_in.wdata[C_CONFIRM];
  assign capture = bus_in.wr && bus_in.addr == A_CMD && bus_in.wdata[C_CAPTURE];
  assign chg = confirm && filt_key(clamp_cfg(st_r.pend)) != filt_key(st_r.cfg);
  assign clr = zero_check_in || range_change_in || chg;
  assign src = st_r.cfg.rel_src_math ? math_in : div_res;

  median_stage u_median (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .en_in    (st_r.cfg.med_en),
    .rank_in  (st_r.cfg.med_rank),
    .clr_in   (clr),
    .smp_in   (reading_in),
    .res_out  (med_res)
  );

  avg_divide u_divide (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .valid_in (div_v),
    .sum_in   (div_sum),
    .cnt_in   (div_cnt),
    .res_out  (div_res)
  );

  ////////////////////////////////////////////////////////////////
  always_comb begin
    logic signed [RD_W-1:0]  x;
    logic signed [SUM_W-1:0] s;
    logic [CNT_W-1:0]        n;
    logic [WIN_W-1:0]        dev;
    logic [WIN_W-1:0]        tol;
    cfg_t                    cl;
    x = med_res.data;
    n = st_r.cfg.average_count;
    s = st_r.sum + SUM_W'(x);
    dev = WIN_W'(abs_w({x[RD_W-1], x} - {st_r.last_avg[RD_W-1], st_r.last_avg}))
          * WIN_W'(PCT_FULL);
    tol = WIN_W'(range_fs_in) * WIN_W'(st_r.cfg.noise_tolerance_pct);
    outside = st_r.cfg.adv_en && st_r.have_avg && dev > tol;
    cl = clamp_cfg(st_r.pend);
    st_nxt = st_r;
    st_nxt.rdata = '0;
    st_nxt.rel.valid = 1'b0;
    div_v = 1'b0;
    div_sum = '0;
    div_cnt = CNT_MIN;

    // Writes land in the pending copy only
    if (bus_in.wr) begin
      case (bus_in.addr)
        A_CTRL: begin
          st_nxt.pend.avg_en = bus_in.wdata[B_AVG_EN];
          st_nxt.pend.stack_control_select = bus_in.wdata[B_MOVING];
          st_nxt.pend.adv_en = bus_in.wdata[B_ADV_EN];
          st_nxt.pend.med_en = bus_in.wdata[B_MED_EN];
          st_nxt.pend.rel_en = bus_in.wdata[B_REL_EN];
          st_nxt.pend.rel_src_math = bus_in.wdata[B_REL_MATH];
        end
        A_COUNT: st_nxt.pend.average_count = bus_in.wdata[CNT_W-1:0];
        A_NOISE_TOLERANCE_PCT: st_nxt.pend.noise_tolerance_pct = bus_in.wdata[CNT_W-1:0];
        A_RANK: st_nxt.pend.med_rank = bus_in.wdata[2:0];
        A_BASE_LO: st_nxt.base_pend[WORD_W-1:0] = bus_in.wdata;
        A_BASE_MID: st_nxt.base_pend[2*WORD_W-1:WORD_W] = bus_in.wdata;
        A_BASE_HI: st_nxt.base_pend[RD_W-1:2*WORD_W] = bus_in.wdata[HI_W-1:0];
        default: ;
      endcase
    end
    if (confirm) begin
      st_nxt.cfg = cl;
      st_nxt.pend = cl;
      st_nxt.base = clamp_base(st_r.base_pend);
      st_nxt.base_pend = clamp_base(st_r.base_pend);
    end else if (bus_in.wr && bus_in.addr == A_CMD && bus_in.wdata[C_CANCEL]) begin
      st_nxt.pend = st_r.cfg;
      st_nxt.base_pend = st_r.base;
    end
    if (math_toggle_in) begin
      st_nxt.cfg.rel_en = 1'b0;
      st_nxt.pend.rel_en = 1'b0;
    end
    // Capture is the setting event, so it wins over a same-cycle toggle
    if (capture) begin
      st_nxt.base = clamp_base(st_r.src_last);
      st_nxt.base_pend = clamp_base(st_r.src_last);
      st_nxt.cfg.rel_en = 1'b1;
      st_nxt.pend.rel_en = 1'b1;
    end

    ////////////////////////////////////////////////////////////////
    if (div_res.valid) begin
      st_nxt.last_avg = div_res.data;
      st_nxt.have_avg = 1'b1;
    end
    if (med_res.valid) begin
      div_v = 1'b1;
      if (!st_r.cfg.avg_en) begin
        div_sum = SUM_W'(x);
      end else if (outside) begin
        st_nxt.stk[0] = x;
        st_nxt.ptr = nxt_ptr('0, n);
        st_nxt.fill = CNT_MIN;
        st_nxt.sum = SUM_W'(x);
        div_sum = SUM_W'(x);
      end else if (st_r.cfg.stack_control_select) begin
        // Moving: oldest entry dropped once full
        if (st_r.fill >= n) begin
          s = s - SUM_W'(signed'(st_r.stk[st_r.ptr]));
        end else begin
          st_nxt.fill = st_r.fill + CNT_MIN;
        end
        st_nxt.stk[st_r.ptr] = x;
        st_nxt.ptr = nxt_ptr(st_r.ptr, n);
        st_nxt.sum = s;
        div_sum = s;
        div_cnt = st_nxt.fill;
      end else begin
        // Repeating: one result per full stack, then flush
        st_nxt.stk[st_r.ptr] = x;
        st_nxt.ptr = nxt_ptr(st_r.ptr, n);
        st_nxt.fill = st_r.fill + CNT_MIN;
        st_nxt.sum = s;
        div_v = 1'b0;
        if (st_r.fill + CNT_MIN >= n) begin
          div_v = 1'b1;
          div_sum = s;
          div_cnt = n;
          st_nxt.fill = '0;
          st_nxt.ptr = '0;
          st_nxt.sum = '0;
        end
      end
    end
    if (clr) begin
      div_v = 1'b0;
      st_nxt.fill = '0;
      st_nxt.ptr = '0;
      st_nxt.sum = '0;
      st_nxt.have_avg = 1'b0;
    end

    ////////////////////////////////////////////////////////////////
    // Baseline is absolute, so no range term enters the subtraction
    if (src.valid) begin
      st_nxt.src_last = src.data;
      st_nxt.rel.valid = 1'b1;
      st_nxt.rel.data = st_r.cfg.rel_en ? src.data - st_r.base : src.data;
    end
    if (div_res.valid) begin
      // Judged before the baseline so a big baseline cannot mask it
      st_nxt.ovf = abs_w({div_res.data[RD_W-1], div_res.data})
                   > (RD_W+1)'(range_fs_in);
    end

    if (bus_in.rd) begin
      case (bus_in.addr)
        A_CTRL: st_nxt.rdata = WORD_W'({st_r.cfg.rel_src_math, st_r.cfg.rel_en,
                                        st_r.cfg.med_en, st_r.cfg.adv_en,
                                        st_r.cfg.stack_control_select, st_r.cfg.avg_en});
        A_COUNT: st_nxt.rdata = WORD_W'(st_r.cfg.average_count);
        A_NOISE_TOLERANCE_PCT: st_nxt.rdata = WORD_W'(st_r.cfg.noise_tolerance_pct);
        A_RANK: st_nxt.rdata = WORD_W'(st_r.cfg.med_rank);
        A_BASE_LO: st_nxt.rdata = st_r.base[WORD_W-1:0];
        A_BASE_MID: st_nxt.rdata = st_r.base[2*WORD_W-1:WORD_W];
        A_BASE_HI: st_nxt.rdata = WORD_W'(st_r.base[RD_W-1:2*WORD_W]);
        A_LAT_LO: st_nxt.rdata = st_r.rel.data[WORD_W-1:0];
        A_LAT_MID: st_nxt.rdata = st_r.rel.data[2*WORD_W-1:WORD_W];
        A_LAT_HI: st_nxt.rdata = WORD_W'(st_r.rel.data[RD_W-1:2*WORD_W]);
        A_STATUS: st_nxt.rdata = WORD_W'({st_r.fill, st_r.have_avg, st_r.ovf,
                                          st_r.pend != st_r.cfg});
        default: st_nxt.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r <= '0;
      st_r.cfg <= CFG_RST;
      st_r.pend <= CFG_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata_out = st_r.rdata;
  assign filt_out = div_res;
  assign rel_out = st_r.rel;
  assign overflow_out = st_r.ovf;

  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  chk_count_range: assert property (
    st_r.cfg.average_count >= CNT_MIN && st_r.cfg.average_count <= CNT_MAX)
    else $error("average count out of range");
  chk_noise_tolerance_pct_range: assert property (
    st_r.cfg.noise_tolerance_pct <= NOISE_TOLERANCE_PCT_MAX)
    else $error("noise tolerance out of range");
  chk_rank_range: assert property (
    st_r.cfg.med_rank >= RANK_MIN && st_r.cfg.med_rank <= RANK_MAX)
    else $error("median rank out of range");
  chk_entry_holds: assert property (
    !confirm |=> $stable(filt_key(st_r.cfg)))
    else $error("filter setting changed without confirm");
  chk_stack_clear: assert property (
    zero_check_in || range_change_in |=> st_r.fill == '0 && !st_r.have_avg)
    else $error("stack not cleared");
  chk_math_drop_rel: assert property (
    math_toggle_in && !capture |=> !st_r.cfg.rel_en)
    else $error("relative survived math toggle");
  chk_range_keeps_rel: assert property (
    range_change_in && !math_toggle_in && st_r.cfg.rel_en |=> st_r.cfg.rel_en)
    else $error("range change dropped relative");
  chk_capture_base: assert property (
    capture |=> st_r.cfg.rel_en && st_r.base == clamp_base($past(st_r.src_last)))
    else $error("capture did not latch baseline");
  chk_rel_subtract: assert property (
    src.valid && st_r.cfg.rel_en |=> rel_out.valid &&
      rel_out.data == $past(src.data) - $past(st_r.base))
    else $error("relative result wrong");
  chk_bypass_pass: assert property (
    med_res.valid && !st_r.cfg.avg_en && !clr |=>
      filt_out.valid && filt_out.data == $past(med_res.data))
    else $error("disabled averaging altered reading");
  chk_repeat_out: assert property (
    med_res.valid && st_r.cfg.avg_en && !st_r.cfg.stack_control_select && !clr
      && !outside && st_r.fill + CNT_MIN < st_r.cfg.average_count |=> !filt_out.valid)
    else $error("repeating output before full count");
  chk_base_limit: assert property (
    $signed(st_r.base) <= BASE_MAX && $signed(st_r.base) >= BASE_MIN)
    else $error("baseline beyond limit");
  cov_moving_full: cover property (
    st_r.cfg.stack_control_select && st_r.fill == st_r.cfg.average_count && med_res.valid);
  cov_window_jump: cover property (med_res.valid && st_r.cfg.avg_en && outside);
  cov_capture: cover property (capture ##1 rel_out.valid);
  cov_confirm_chg: cover property (chg);
endmodule
`default_nettype wire

// ### bench/reading_source.sv
// Behavioural converter model that feeds one reading per request
`timescale 1ns/1ps
`default_nettype none
module reading_source
  import filt_pkg::*;
(
  input  wire logic clk_in,
  output var  rd_t  rd_out
);
  initial rd_out = '0;
  // Idle data is inverted so a stale value never passes for a fresh one
  task automatic send(input logic [RD_W-1:0] v);
    @(posedge clk_in);
    rd_out <= '{valid: 1'b1, data: v};
    @(posedge clk_in);
    rd_out <= '{valid: 1'b0, data: ~v};
  endtask
endmodule
`default_nettype wire

// ### bench/test_reading_filter_and_relative_offset.sv
// Self-checking bench for the reading filter and relative stage
`timescale 1ns/1ps
`default_nettype none
module test_reading_filter_and_relative_offset
  import filt_pkg::*;
;
  logic              clk_in;
  logic              rst_n_in;
  bus_t              bus_in;
  logic [WORD_W-1:0] rdata_out;
  rd_t               reading_in;
  rd_t               math_in;
  logic [RD_W-1:0]   range_fs_in;
  logic [2:0]        ev;
  rd_t               filt_out;
  rd_t               rel_out;
  logic              overflow_out;
  int                miscompares = 0;
  int                cmp_count = 0;
  int                cycles = 0;

  reading_source src (.clk_in(clk_in), .rd_out(reading_in));

  reading_filter_and_relative_offset dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .bus_in(bus_in), .rdata_out(rdata_out),
    .reading_in(reading_in), .range_fs_in(range_fs_in), .zero_check_in(ev[0]),
    .range_change_in(ev[1]), .math_toggle_in(ev[2]), .math_in(math_in),
    .filt_out(filt_out), .rel_out(rel_out), .overflow_out(overflow_out));

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [RD_W-1:0] exp, input logic [RD_W-1:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [WORD_W-1:0] d);
    @(posedge clk_in);
    bus_in <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_in);
    bus_in <= '0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [WORD_W-1:0] exp);
    @(posedge clk_in);
    bus_in <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: '0};
    @(posedge clk_in);
    bus_in <= '0;
    #1;
    check("rdata", RD_W'(exp), RD_W'(rdata_out));
  endtask

  task automatic pulse(input int i);
    @(posedge clk_in);
    ev[i] <= 1'b1;
    @(posedge clk_in);
    ev <= '0;
  endtask

  // Waits a bounded time, so a lost reading shows up as a mismatch, not a hang
  task automatic run(input logic [RD_W-1:0] v, input logic [RD_W-1:0] ef, input logic rel,
                     input logic [RD_W-1:0] er);
    int n;
    n = 0;
    src.send(v);
    #1;
    while (filt_out.valid !== 1'b1 && n < 40) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    check("filt_valid", 1'b1, filt_out.valid);
    check("filt_data", ef, filt_out.data);
    @(posedge clk_in);
    #1;
    check("filt_pulse", 1'b0, filt_out.valid);
    check("rel_valid", 1'b1, rel_out.valid);
    if (rel) check("rel_data", er, rel_out.data);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic test_defaults();
    rd_chk(A_COUNT, 32'h0000000a);
    rd_chk(A_CTRL, 32'h00000000);
    rd_chk(A_NOISE_TOLERANCE_PCT, 32'h00000000);
    rd_chk(A_RANK, 32'h00000001);
    rd_chk(A_BASE_LO, 32'h00000000);
    rd_chk(4'hf, 32'h00000000);
  endtask

  task automatic test_entry();
    wr(A_COUNT, 32'h00000014);
    rd_chk(A_COUNT, 32'h0000000a);
    wr(A_CMD, 32'h00000002);
    wr(A_CMD, 32'h00000001);
    rd_chk(A_COUNT, 32'h0000000a);
    wr(A_COUNT, 32'h00000014);
    wr(A_CMD, 32'h00000001);
    rd_chk(A_COUNT, 32'h00000014);
    wr(A_COUNT, 32'h0000007f);
    wr(A_NOISE_TOLERANCE_PCT, 32'h0000007f);
    wr(A_CMD, 32'h00000001);
    rd_chk(A_COUNT, 32'h00000064);
    rd_chk(A_NOISE_TOLERANCE_PCT, 32'h00000069);
  endtask

  task automatic test_avg();
    run(72'h123, 72'h123, 1'b0, '0);
    wr(A_COUNT, 32'h00000002);
    wr(A_CTRL, 32'h00000001);
    wr(A_CMD, 32'h00000001);
    src.send(72'h0a);
    pulse(0);
    src.send(72'h14);
    run(72'h1e, 72'h19, 1'b0, '0);
    wr(A_CTRL, 32'h00000003);
    wr(A_CMD, 32'h00000001);
    run(72'h28, 72'h28, 1'b0, '0);
    run(72'h3c, 72'h32, 1'b0, '0);
  endtask

  task automatic test_median();
    wr(A_CTRL, 32'h0000000b);
    wr(A_CMD, 32'h00000001);
    src.send(72'h50);
    src.send(72'h10);
    run(72'h90, 72'h50, 1'b0, '0);
    run(72'h20, 72'h38, 1'b0, '0);
    wr(A_RANK, 32'h00000007);
    wr(A_CMD, 32'h00000001);
    rd_chk(A_RANK, 32'h00000005);
  endtask

  task automatic test_window();
    range_fs_in <= 72'h32;
    wr(A_COUNT, 32'h00000004);
    wr(A_NOISE_TOLERANCE_PCT, 32'h0000000a);
    wr(A_CTRL, 32'h00000007);
    wr(A_CMD, 32'h00000001);
    run(72'h20, 72'h20, 1'b0, '0);
    run(72'h22, 72'h21, 1'b0, '0);
    check("overflow", 1'b0, overflow_out);
    run(72'h60, 72'h60, 1'b0, '0);
    run(72'h62, 72'h61, 1'b0, '0);
  endtask

  task automatic test_math();
    wr(A_CTRL, 32'h00000030);
    wr(A_CMD, 32'h00000001);
    @(posedge clk_in);
    math_in <= '{valid: 1'b1, data: 72'hc8};
    @(posedge clk_in);
    math_in <= '0;
    #1;
    check("math_rel_valid", 1'b1, rel_out.valid);
    check("math_rel_data", 72'h64, rel_out.data);
    src.send(72'h10);
    repeat (3) begin
      @(posedge clk_in);
      #1;
      check("math_only", 1'b0, rel_out.valid);
    end
    wr(A_BASE_HI, 32'h0000007f);
    wr(A_CMD, 32'h00000001);
    rd_chk(A_BASE_HI, WORD_W'(BASE_MAX[RD_W-1:2*WORD_W]));
    rd_chk(A_BASE_LO, BASE_MAX[WORD_W-1:0]);
  endtask

  task automatic test_rel();
    wr(A_CTRL, 32'h00000010);
    wr(A_BASE_LO, 32'h00000005);
    wr(A_CMD, 32'h00000001);
    range_fs_in <= 72'h32;
    run(72'h64, 72'h64, 1'b1, 72'h5f);
    check("overflow", 1'b1, overflow_out);
    wr(A_CMD, 32'h00000004);
    run(72'h82, 72'h82, 1'b1, 72'h1e);
    check("overflow", 1'b1, overflow_out);
    pulse(2);
    rd_chk(A_CTRL, 32'h00000000);
    wr(A_CTRL, 32'h00000010);
    wr(A_CMD, 32'h00000001);
    rd_chk(A_BASE_LO, 32'h00000064);
    run(72'h6e, 72'h6e, 1'b1, 72'h0a);
    pulse(1);
    rd_chk(A_CTRL, 32'h00000010);
    run(72'h96, 72'h96, 1'b1, 72'h32);
    rd_chk(A_LAT_LO, 32'h00000032);
  endtask

  task automatic final_report();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  // Whole run needs well under a thousand cycles
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      final_report();
    end
  end

  initial begin
    rst_n_in = 1'b0;
    bus_in = '0;
    math_in = '0;
    range_fs_in = 72'hffff;
    ev = '0;
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'b1;
    test_defaults();
    test_entry();
    test_avg();
    test_median();
    test_window();
    test_rel();
    test_math();
    final_report();
  end
endmodule
`default_nettype wire
